//--- core/tsfc_pkg.sv
// Operation
// R1 - Two-speed only with switchover, select 00, crystal
// R2 - Start after power-up timer and every wake-up
// R3 - Run internal while timer counts 1024 edges
// R4 - Wait internal fall, set status, hold, switch; status is set only when switching to the primary source, not for timer1
// R5 - Timer1 or crystal switch waits 1024 cycles
// R6 - Monitor enabled by config, watches every external
// R7 - Sample clock is low oscillator divided by 64
// R8 - Latch set by fall, cleared by sample rise
// R9 - Failure selects internal, sets flag, maybe interrupt
// R10 - Stay internal until firmware switches back
// R11 - Reset, sleep or select change clears failure
// R12 - Select change restarts timer, running internal
// R13 - Flag set again while failure persists; here only a new failure detected in ST_EXT sets it
// R14 - Clock and RC modes skip the timer
// R15 - Monitor enable also enables two-speed start
// R16 - Config PLL bit overrides software PLL bit
// R17 - Frequency select decode, default 0111
// R18 - Select decodes internal, timer1 or configured
// R19 - Timer1 ready reads 1 when timer1 off
// R20 - Status reports oscillator ready, lock, stable
// R21 - Status bit 5 shows external clock running
// R22 - Reset clears select; automatic switches leave it
// R23 - Sleep aborts count, keeps status clear
// R24 - Fail flag sticky until firmware clears it
package tsfc_pkg;

   // ==========================================================
   // Register map
   localparam logic [1:0] OSC_CTL = 2'h0;
   localparam logic [1:0] OSC_STAT = 2'h1;
   localparam logic [1:0] OSC_FAIL = 2'h2;
   localparam int CTL_PLL_BIT = 7;
   localparam int CTL_IFS_LSB = 3;
   localparam int CTL_SCS_LSB = 0;
   localparam int FAIL_FLAG_BIT = 7;
   localparam int FAIL_IE_BIT = 6;
   localparam int STAT_T1R_BIT = 7;
   localparam logic [3:0] IFS_RST = 4'h7;
   localparam logic [3:0] IFS_8M = 4'hE;
   localparam logic [1:0] SCS_RST = 2'h0;

   // ==========================================================
   // Timing counts
   localparam int OST_CYCLES = 1024;
   localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);
   localparam int LFO_DIV = 64;
   localparam logic [4:0] LFO_HALF_LAST = 5'(LFO_DIV / 2 - 1);

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      MODE_LP = 3'h0,
      MODE_XT = 3'h1,
      MODE_HS = 3'h2,
      MODE_RC = 3'h3,
      MODE_INTERNAL_OSC_BLOCK = 3'h4,
      MODE_EC = 3'h5
   } tsfc_mode_t;

   typedef enum logic [1:0] {
      SRC_INT = 2'h0,
      SRC_PRI = 2'h1,
      SRC_T1 = 2'h2
   } tsfc_src_t;

   typedef enum logic [1:0] {
      KIND_LF = 2'h0,
      KIND_MF = 2'h1,
      KIND_HF = 2'h2
   } tsfc_kind_t;

   typedef enum logic [2:0] {
      ST_INT = 3'h0,
      ST_COUNT = 3'h1,
      ST_WAIT = 3'h3,
      ST_HOLD = 3'h2,
      ST_EXT = 3'h6
   } tsfc_state_t;

   typedef struct packed {
      logic switchover;
      logic fsm_en;
      logic pll_en;
      tsfc_mode_t mode;
   } tsfc_cfg_t;

   typedef struct packed {
      logic t1_ready;
      logic t1_en;
      logic pll;
      logic hf_ready;
      logic hf_lock;
      logic mf_ready;
      logic lf_ready;
      logic hf_stable;
   } tsfc_ready_t;

   typedef struct packed {
      logic sw_pll_enable;
      logic [3:0] ifs;
      logic [1:0] system_clock_select;
   } tsfc_ctl_t;

   typedef struct packed {
      logic [2:0] ext_sy;
      logic [2:0] t1_sy;
      logic [2:0] lfo_sy;
      logic [2:0] int_sy;
      logic ext_lv;
      logic t1_lv;
      logic lfo_lv;
      logic int_lv;
      logic [4:0] lfo_cnt;
      logic smp;
      logic latch;
      logic [10:0] startup_timer;
      tsfc_state_t st;
      tsfc_src_t src;
      logic hold;
      logic stall;
      logic sts;
      logic fail_cond;
      logic flag;
      logic irq_en;
      logic irq;
      logic pll_on;
      tsfc_kind_t kind;
      logic pll32;
      tsfc_ctl_t ctl;
      logic [7:0] rdata;
   } tsfc_regs_t;

   localparam tsfc_regs_t REGS_RST = '{
      ctl: '{sw_pll_enable: 1'b0, ifs: IFS_RST, system_clock_select: SCS_RST},
      st: ST_INT,
      src: SRC_INT,
      kind: KIND_MF,
      default: '0
   };

endpackage : tsfc_pkg

//--- core/tsfc_top.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module tsfc_top (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Configuration word
   input wire tsfc_pkg::tsfc_cfg_t cfg,
   // Power and sleep events
   input wire logic por_done,
   input wire logic sleep_enter,
   input wire logic wake_up,
   // Oscillator pins
   input wire logic ext_osc_clk,
   input wire logic t1_osc_clk,
   input wire logic low_freq_osc,
   input wire logic int_osc_clk,
   // Oscillator ready inputs
   input wire tsfc_pkg::tsfc_ready_t osc_rdy,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Clock control
   output tsfc_pkg::tsfc_src_t clk_src,
   output logic sys_clk_hold,
   output logic cpu_stall,
   output logic pll_on,
   output logic [3:0] int_freq_sel,
   output tsfc_pkg::tsfc_kind_t int_osc_kind,
   output logic int_pll_32m,
   output logic startup_status,
   output logic fail_active,
   output logic osc_fail_flag,
   output logic osc_fail_irq
);

   // ==========================================================
   // Helpers
   function automatic logic tsfc_settle(input logic [2:0] sy,
                                        input logic lv);
      tsfc_settle = (sy[1] == sy[2]) ? sy[2] : lv;
   endfunction : tsfc_settle

   function automatic logic tsfc_is_xtal(input tsfc_pkg::tsfc_mode_t m);
      tsfc_is_xtal = (m == tsfc_pkg::MODE_LP) || (m == tsfc_pkg::MODE_XT) ||
                     (m == tsfc_pkg::MODE_HS);
   endfunction : tsfc_is_xtal

   function automatic tsfc_pkg::tsfc_src_t tsfc_target(
      input logic [1:0] system_clock_select, input tsfc_pkg::tsfc_mode_t m);
      if (system_clock_select[1]) begin
         tsfc_target = tsfc_pkg::SRC_INT; // R18
      end else if (system_clock_select[0]) begin
         tsfc_target = tsfc_pkg::SRC_T1; // R18
      end else if (m == tsfc_pkg::MODE_INTERNAL_OSC_BLOCK) begin
         tsfc_target = tsfc_pkg::SRC_INT;
      end else begin
         tsfc_target = tsfc_pkg::SRC_PRI; // R18
      end
   endfunction : tsfc_target

   function automatic tsfc_pkg::tsfc_kind_t tsfc_kind(input logic [3:0] f);
      if (f[3:1] == 3'h0) begin
         tsfc_kind = tsfc_pkg::KIND_LF; // R17
      end else if (f == 4'h2 || (f[3:2] == 2'h1)) begin
         tsfc_kind = tsfc_pkg::KIND_MF; // R17
      end else begin
         tsfc_kind = tsfc_pkg::KIND_HF; // R17
      end
   endfunction : tsfc_kind

   // ==========================================================
   // State
   tsfc_pkg::tsfc_regs_t r;
   tsfc_pkg::tsfc_regs_t n;

   logic ext_lv;
   logic t1_lv;
   logic lfo_lv;
   logic int_lv;
   logic ext_fall;
   logic t1_fall;
   logic lfo_rise;
   logic int_fall;
   logic cnt_edge;
   logic xtal;
   logic tsu_go;
   logic wr_ctl;
   logic wr_fail;
   logic scs_chg;
   logic restart;
   logic [1:0] new_scs;
   tsfc_pkg::tsfc_src_t tgt;
   tsfc_pkg::tsfc_src_t go_tgt;
   logic mon_on;
   logic smp_tick;
   logic smp_rise;
   logic smp_fall;
   logic fail_det;
   logic t1r;

   assign ext_lv = tsfc_settle(r.ext_sy, r.ext_lv);
   assign t1_lv = tsfc_settle(r.t1_sy, r.t1_lv);
   assign lfo_lv = tsfc_settle(r.lfo_sy, r.lfo_lv);
   assign int_lv = tsfc_settle(r.int_sy, r.int_lv);
   assign ext_fall = r.ext_lv & ~ext_lv;
   assign t1_fall = r.t1_lv & ~t1_lv;
   assign lfo_rise = ~r.lfo_lv & lfo_lv;
   assign int_fall = r.int_lv & ~int_lv;

   assign xtal = tsfc_is_xtal(cfg.mode);
   assign tgt = tsfc_target(r.ctl.system_clock_select, cfg.mode);
   // Edges of the source being started or watched
   assign cnt_edge = (tgt == tsfc_pkg::SRC_T1) ? t1_fall : ext_fall; // R6
   assign wr_ctl = reg_wr && (reg_addr == tsfc_pkg::OSC_CTL);
   assign wr_fail = reg_wr && (reg_addr == tsfc_pkg::OSC_FAIL);
   assign scs_chg = wr_ctl &&
      (reg_wdata[tsfc_pkg::CTL_SCS_LSB +: 2] != r.ctl.system_clock_select);
   assign new_scs = scs_chg ? reg_wdata[tsfc_pkg::CTL_SCS_LSB +: 2]
                            : r.ctl.system_clock_select;
   assign go_tgt = tsfc_target(new_scs, cfg.mode);
   assign restart = scs_chg | por_done | wake_up; // R2 R12
   assign tsu_go = (cfg.switchover | cfg.fsm_en) && // R1 R15
                   (new_scs == 2'h0) && xtal;

   // Sample clock: low oscillator divided by 64
   assign smp_tick = lfo_rise && (r.lfo_cnt == tsfc_pkg::LFO_HALF_LAST);
   assign smp_rise = smp_tick & ~r.smp;
   assign smp_fall = smp_tick & r.smp;
   assign mon_on = cfg.fsm_en && (r.st == tsfc_pkg::ST_EXT); // R6 R14
   assign fail_det = mon_on && smp_fall && !(r.latch || cnt_edge); // R8
   assign t1r = osc_rdy.t1_en ? osc_rdy.t1_ready : 1'b1; // R19

   // ==========================================================
   // Next state
   always_comb begin
      n = r;
      n.ext_sy = {r.ext_sy[1:0], ext_osc_clk};
      n.t1_sy = {r.t1_sy[1:0], t1_osc_clk};
      n.lfo_sy = {r.lfo_sy[1:0], low_freq_osc};
      n.int_sy = {r.int_sy[1:0], int_osc_clk};
      n.ext_lv = ext_lv;
      n.t1_lv = t1_lv;
      n.lfo_lv = lfo_lv;
      n.int_lv = int_lv;

      if (lfo_rise) begin
         n.lfo_cnt = r.lfo_cnt + 5'h01; // R7
         if (smp_tick) begin
            n.smp = ~r.smp; // R7
         end
      end
      if (smp_rise) begin
         n.latch = 1'b0; // R8
      end
      if (cnt_edge) begin
         n.latch = 1'b1; // R8
      end

      unique case (r.st)
         tsfc_pkg::ST_INT: begin
            n.src = tsfc_pkg::SRC_INT; // R10
         end
         tsfc_pkg::ST_COUNT: begin
            if (cnt_edge) begin
               if (r.startup_timer == tsfc_pkg::OST_LAST) begin
                  n.st = tsfc_pkg::ST_WAIT; // R3 R5
               end else begin
                  n.startup_timer = r.startup_timer + 11'h001; // R3 R5
               end
            end
         end
         tsfc_pkg::ST_WAIT: begin
            if (int_fall) begin
               n.st = tsfc_pkg::ST_HOLD; // R4
               n.hold = 1'b1; // R4
               n.sts = (tgt == tsfc_pkg::SRC_PRI); // R4 R21
            end
         end
         tsfc_pkg::ST_HOLD: begin
            if (cnt_edge) begin
               n.st = tsfc_pkg::ST_EXT; // R4
               n.hold = 1'b0;
               n.src = tgt; // R4
               n.stall = 1'b0;
               n.fail_cond = 1'b0; // R12
               n.latch = 1'b1;
            end
         end
         tsfc_pkg::ST_EXT: begin
            if (fail_det) begin
               n.st = tsfc_pkg::ST_INT; // R9
               n.src = tsfc_pkg::SRC_INT; // R9
               n.sts = 1'b0; // R21
               n.fail_cond = 1'b1; // R9
            end
         end
         default: begin
            n.st = tsfc_pkg::ST_INT;
            n.src = tsfc_pkg::SRC_INT;
            n.hold = 1'b0;
         end
      endcase

      // Start sequence for the selected source
      if (restart) begin
         n.sts = 1'b0;
         n.hold = 1'b0;
         n.startup_timer = 11'h000; // R12
         n.src = tsfc_pkg::SRC_INT; // R3 R12
         n.stall = 1'b0;
         if (scs_chg) begin
            n.fail_cond = 1'b0; // R11
         end
         if (go_tgt == tsfc_pkg::SRC_INT) begin
            n.st = tsfc_pkg::ST_INT;
         end else if (go_tgt == tsfc_pkg::SRC_PRI && !xtal) begin
            n.st = tsfc_pkg::ST_WAIT; // R14
         end else begin
            n.st = tsfc_pkg::ST_COUNT; // R5
            n.stall = (go_tgt == tsfc_pkg::SRC_PRI) && !tsu_go; // R1 R15
         end
      end

      if (sleep_enter) begin
         n.st = tsfc_pkg::ST_INT; // R23
         n.startup_timer = 11'h000; // R23
         n.sts = 1'b0; // R23
         n.hold = 1'b0;
         n.stall = 1'b0;
         n.src = tsfc_pkg::SRC_INT;
         n.fail_cond = 1'b0; // R11
      end

      // Register writes; automatic switches never touch the select
      if (wr_ctl) begin
         n.ctl.sw_pll_enable = reg_wdata[tsfc_pkg::CTL_PLL_BIT];
         n.ctl.ifs = reg_wdata[tsfc_pkg::CTL_IFS_LSB +: 4];
         n.ctl.system_clock_select = reg_wdata[tsfc_pkg::CTL_SCS_LSB +: 2]; // R22
      end
      if (wr_fail) begin
         if (!reg_wdata[tsfc_pkg::FAIL_FLAG_BIT]) begin
            n.flag = 1'b0; // R24
         end
         n.irq_en = reg_wdata[tsfc_pkg::FAIL_IE_BIT];
      end
      if (fail_det) begin
         n.flag = 1'b1; // R9 R13
      end
      n.irq = n.flag & n.irq_en; // R9
      n.pll_on = cfg.pll_en | n.ctl.sw_pll_enable; // R16
      n.kind = tsfc_kind(n.ctl.ifs); // R17
      n.pll32 = n.pll_on && (n.ctl.ifs == tsfc_pkg::IFS_8M); // R17

      n.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            tsfc_pkg::OSC_CTL: begin
               n.rdata = {r.ctl.sw_pll_enable, r.ctl.ifs, 1'b0, r.ctl.system_clock_select};
            end
            tsfc_pkg::OSC_STAT: begin
               n.rdata = {t1r, osc_rdy.pll, r.sts, osc_rdy.hf_ready, // R20
                          osc_rdy.hf_lock, osc_rdy.mf_ready,
                          osc_rdy.lf_ready, osc_rdy.hf_stable}; // R20 R21
            end
            tsfc_pkg::OSC_FAIL: begin
               n.rdata = {r.flag, r.irq_en, 6'h00};
            end
            default: begin
               n.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= tsfc_pkg::REGS_RST; // R22
      end else if (clk_en) begin
         r <= n;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata = r.rdata;
   assign clk_src = r.src;
   assign sys_clk_hold = r.hold;
   assign cpu_stall = r.stall;
   assign pll_on = r.pll_on;
   assign int_freq_sel = r.ctl.ifs;
   assign int_osc_kind = r.kind;
   assign int_pll_32m = r.pll32;
   assign startup_status = r.sts;
   assign fail_active = r.fail_cond;
   assign osc_fail_flag = r.flag;
   assign osc_fail_irq = r.irq;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   logic any_evt;
   logic evt_no_wake;
   assign any_evt = restart | sleep_enter;
   assign evt_no_wake = scs_chg | por_done | sleep_enter;

   AST_TSU_MODE: assert property ( // R1
      (clk_en && wake_up && !evt_no_wake && tgt == tsfc_pkg::SRC_PRI
       && xtal) |=> (r.st == tsfc_pkg::ST_COUNT && cpu_stall == !$past(tsu_go)))
      else $error("two-speed start entry wrong");
   AST_OST_DONE: assert property ( // R3
      (clk_en && r.st == tsfc_pkg::ST_COUNT && cnt_edge &&
       r.startup_timer == tsfc_pkg::OST_LAST && !any_evt) |=> r.st == tsfc_pkg::ST_WAIT)
      else $error("start-up timer did not expire at 1024");
   AST_OST_MIN: assert property ( // R5
      (r.st == tsfc_pkg::ST_WAIT && $past(r.st) == tsfc_pkg::ST_COUNT)
      |-> $past(r.startup_timer) == tsfc_pkg::OST_LAST)
      else $error("start-up timer expired early");
   AST_HOLD_SWITCH: assert property ( // R4
      (clk_en && r.st == tsfc_pkg::ST_HOLD && cnt_edge && !any_evt)
      |=> (clk_src == $past(tgt) && !sys_clk_hold))
      else $error("clock not switched after hold");
   AST_STS_HOLD: assert property ( // R21
      $rose(startup_status) |-> sys_clk_hold)
      else $error("status set outside hold phase");
   AST_DIV64: assert property ( // R7
      $changed(r.smp) |-> ($past(r.lfo_cnt) == tsfc_pkg::LFO_HALF_LAST &&
                           $past(lfo_rise)))
      else $error("sample clock divide wrong");
   AST_FAIL_SW: assert property ( // R9
      (clk_en && fail_det && !any_evt) |=>
      (clk_src == tsfc_pkg::SRC_INT && osc_fail_flag && fail_active))
      else $error("failure not handled");
   AST_IRQ: assert property ( // R9
      (clk_en && n.flag && n.irq_en) |=> osc_fail_irq)
      else $error("interrupt missing");
   AST_STICKY: assert property ( // R24
      (osc_fail_flag && !(wr_fail && !reg_wdata[tsfc_pkg::FAIL_FLAG_BIT]))
      |=> osc_fail_flag)
      else $error("fail flag dropped");
   AST_SLEEP: assert property ( // R23
      (clk_en && sleep_enter) |=> (!startup_status && r.st == tsfc_pkg::ST_INT))
      else $error("sleep did not abort start-up");
   AST_PLL: assert property ( // R16
      (clk_en && cfg.pll_en) |=> pll_on)
      else $error("PLL not forced on");
   AST_T1R: assert property ( // R19
      (clk_en && reg_rd && reg_addr == tsfc_pkg::OSC_STAT && !osc_rdy.t1_en)
      |=> reg_rdata[tsfc_pkg::STAT_T1R_BIT])
      else $error("timer1 ready not forced");
   AST_RESTART: assert property ( // R12
      (clk_en && scs_chg && !sleep_enter) |=> (r.startup_timer == 11'h000 && !fail_active))
      else $error("select change did not restart");

   COV_SWITCH: cover property (r.st == tsfc_pkg::ST_HOLD ##1
                               r.st == tsfc_pkg::ST_EXT);
   COV_FAIL: cover property (clk_en && fail_det);
   COV_SLEEP_ABORT: cover property (r.st == tsfc_pkg::ST_COUNT && sleep_enter);

endmodule : tsfc_top

//--- dv/tsfc_osc_model.sv
`timescale 1ns/1ps
// ==========================================================
// Free-running oscillators; the external one can be stopped
module tsfc_osc_model #(
   parameter int EXT_HALF = 24,
   parameter int T1_HALF = 32,
   parameter int LFO_HALF = 24,
   parameter int INT_HALF = 40
) (
   // Control from the bench
   input wire logic ext_run,
   // Oscillator levels
   output logic ext_osc_clk,
   output logic t1_osc_clk,
   output logic low_freq_osc,
   output logic int_osc_clk
);
   initial begin
      ext_osc_clk = 1'b0;
      t1_osc_clk = 1'b0;
      low_freq_osc = 1'b0;
      int_osc_clk = 1'b0;
   end
   // A stopped crystal sticks at its last level
   always #(EXT_HALF) begin
      if (ext_run) begin
         ext_osc_clk = ~ext_osc_clk;
      end
   end
   always #(T1_HALF) t1_osc_clk = ~t1_osc_clk;
   initial begin
      #3;
      forever #(LFO_HALF) low_freq_osc = ~low_freq_osc;
   end
   initial begin
      #5;
      forever #(INT_HALF) int_osc_clk = ~int_osc_clk;
   end
endmodule : tsfc_osc_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
failures++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
`define WAITC(c, n) begin cyc = 0; while (!(c) && cyc < (n)) begin \
@(posedge sys_clk); #1; cyc++; end end
module tb_top;
   typedef struct {
      logic wr;
      logic [1:0] a;
      logic [7:0] d;
      logic [7:0] exp;
      tsfc_pkg::tsfc_kind_t kind;
   } tsfcv_row_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   tsfc_pkg::tsfc_cfg_t cfg;
   logic por_done = 1'b0;
   logic sleep_enter = 1'b0;
   logic wake_up = 1'b0;
   logic ext_run = 1'b1;
   logic clk_en = 1'b1;
   logic ext_osc_clk, t1_osc_clk, low_freq_osc, int_osc_clk;
   tsfc_pkg::tsfc_ready_t osc_rdy = 8'h2A;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, rv;
   tsfc_pkg::tsfc_src_t clk_src;
   tsfc_pkg::tsfc_kind_t int_osc_kind;
   logic sys_clk_hold, cpu_stall, pll_on, int_pll_32m, startup_status;
   logic fail_active, osc_fail_flag, osc_fail_irq;
   logic [3:0] int_freq_sel;
   int failures = 0;
   int check_count = 0;
   int cyc, total;
   tsfcv_row_t rows [10] = '{
      '{1'b0, 2'h0, 8'h00, 8'h38, tsfc_pkg::KIND_MF},
      '{1'b1, 2'h0, 8'h00, 8'h00, tsfc_pkg::KIND_LF},
      '{1'b1, 2'h0, 8'h08, 8'h08, tsfc_pkg::KIND_LF},
      '{1'b1, 2'h0, 8'h10, 8'h10, tsfc_pkg::KIND_MF},
      '{1'b1, 2'h0, 8'h74, 8'h70, tsfc_pkg::KIND_HF},
      '{1'b1, 2'h0, 8'h78, 8'h78, tsfc_pkg::KIND_HF},
      '{1'b1, 2'h0, 8'h38, 8'h38, tsfc_pkg::KIND_MF},
      '{1'b1, 2'h3, 8'hFF, 8'h00, tsfc_pkg::KIND_MF},
      '{1'b1, 2'h2, 8'h40, 8'h40, tsfc_pkg::KIND_MF},
      '{1'b1, 2'h1, 8'hFF, 8'hCA, tsfc_pkg::KIND_MF}
   };

   tsfc_osc_model u_tsfc_osc_model (.ext_run(ext_run),
      .ext_osc_clk(ext_osc_clk), .t1_osc_clk(t1_osc_clk),
      .low_freq_osc(low_freq_osc), .int_osc_clk(int_osc_clk));
   tsfc_top u_tsfc_top (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
      .cfg(cfg), .por_done(por_done), .sleep_enter(sleep_enter),
      .wake_up(wake_up), .ext_osc_clk(ext_osc_clk),
      .t1_osc_clk(t1_osc_clk), .low_freq_osc(low_freq_osc),
      .int_osc_clk(int_osc_clk), .osc_rdy(osc_rdy), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .clk_src(clk_src),
      .sys_clk_hold(sys_clk_hold), .cpu_stall(cpu_stall),
      .pll_on(pll_on), .int_freq_sel(int_freq_sel),
      .int_osc_kind(int_osc_kind), .int_pll_32m(int_pll_32m),
      .startup_status(startup_status), .fail_active(fail_active),
      .osc_fail_flag(osc_fail_flag), .osc_fail_irq(osc_fail_irq));

   // ==========================================================
   // Clock and run limit
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      total = 0;
      forever begin
         @(posedge sys_clk);
         total++;
         if (total >= 90000) begin
            failures++;
            stop_test();
         end
      end
   end

   // ==========================================================
   // Register port and event tasks
   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read
   task automatic pulse(input int which);
      @(posedge sys_clk);
      if (which == 0) por_done <= 1'b1;
      else if (which == 1) wake_up <= 1'b1;
      else sleep_enter <= 1'b1;
      @(posedge sys_clk);
      por_done <= 1'b0;
      wake_up <= 1'b0;
      sleep_enter <= 1'b0;
      #1;
   endtask : pulse
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   // ==========================================================
   // Main sequence
   initial begin
      cfg = '{switchover: 1'b0, fsm_en: 1'b1, pll_en: 1'b0,
              mode: tsfc_pkg::MODE_XT};
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) reg_write(rows[i].a, rows[i].d);
         reg_read(rows[i].a, rv);
         `CHK("reg", rows[i].exp, rv)
         if (rows[i].a == 2'h0) begin
            `CHK("freq", rows[i].exp[6:3], int_freq_sel)
            `CHK("kind", rows[i].kind, int_osc_kind)
         end
      end
      // A write while the enable is low is not taken
      clk_en <= 1'b0;
      reg_write(2'h0, 8'h00);
      clk_en <= 1'b1;
      reg_read(2'h0, rv);
      `CHK("frozen", 8'h38, rv)
      osc_rdy <= 8'h6A;
      reg_read(2'h1, rv);
      `CHK("status", 8'h4A, rv)
      reg_write(2'h0, 8'hF0);
      repeat (3) @(posedge sys_clk);
      `CHK("pll sw", 1'b1, pll_on)
      `CHK("pll 32", 1'b1, int_pll_32m)
      reg_write(2'h0, 8'h38);
      repeat (3) @(posedge sys_clk);
      `CHK("pll off", 1'b0, pll_on)
      cfg.pll_en <= 1'b1;
      repeat (3) @(posedge sys_clk);
      `CHK("pll cfg", 1'b1, pll_on)
      // Two-speed start on a crystal
      pulse(0);
      repeat (50) @(posedge sys_clk);
      `CHK("src count", tsfc_pkg::SRC_INT, clk_src)
      `CHK("stall", 1'b0, cpu_stall)
      `WAITC(sys_clk_hold === 1'b1, 7000)
      `CHK("ost span", 1'b1, cyc >= 6080 && cyc <= 6130)
      `CHK("sts", 1'b1, startup_status)
      `WAITC(clk_src === tsfc_pkg::SRC_PRI, 20)
      `CHK("src ext", tsfc_pkg::SRC_PRI, clk_src)
      `CHK("hold", 1'b0, sys_clk_hold)
      reg_read(2'h1, rv);
      `CHK("sts bit", 1'b1, rv[5])
      // Failure of the crystal
      ext_run <= 1'b0;
      `WAITC(fail_active === 1'b1, 600)
      `CHK("fail", 1'b1, fail_active)
      `CHK("src fail", tsfc_pkg::SRC_INT, clk_src)
      `CHK("sts fail", 1'b0, startup_status)
      repeat (2) @(posedge sys_clk);
      `CHK("irq", 1'b1, osc_fail_irq)
      reg_read(2'h0, rv);
      `CHK("scs kept", 8'h38, rv)
      ext_run <= 1'b1;
      repeat (300) @(posedge sys_clk);
      `CHK("stay int", tsfc_pkg::SRC_INT, clk_src)
      reg_read(2'h2, rv);
      `CHK("flag held", 8'hC0, rv)
      reg_write(2'h2, 8'h40);
      reg_read(2'h2, rv);
      `CHK("flag clr", 8'h40, rv)
      reg_write(2'h0, 8'h3A);
      #1;
      `CHK("fail clr", 1'b0, fail_active)
      `CHK("src int", tsfc_pkg::SRC_INT, clk_src)
      reg_write(2'h0, 8'h38);
      repeat (100) @(posedge sys_clk);
      `CHK("restart", tsfc_pkg::SRC_INT, clk_src)
      `WAITC(clk_src === tsfc_pkg::SRC_PRI, 7000)
      `CHK("back ext", tsfc_pkg::SRC_PRI, clk_src)
      ext_run <= 1'b0;
      `WAITC(osc_fail_flag === 1'b1, 600)
      `CHK("flag again", 1'b1, osc_fail_flag)
      // Sleep clears the condition and aborts a count
      pulse(2);
      `CHK("sleep clr", 1'b0, fail_active)
      ext_run <= 1'b1;
      pulse(1);
      repeat (200) @(posedge sys_clk);
      pulse(2);
      repeat (7000) @(posedge sys_clk);
      #1;
      `CHK("abort", 1'b0, startup_status)
      `CHK("abort src", tsfc_pkg::SRC_INT, clk_src)
      // Crystal with two-speed off keeps the core waiting
      cfg.fsm_en <= 1'b0;
      pulse(1);
      `CHK("stall on", 1'b1, cpu_stall)
      pulse(2);
      `CHK("stall off", 1'b0, cpu_stall)
      cfg.fsm_en <= 1'b1;
      // Timer1 oscillator selection
      reg_write(2'h0, 8'h39);
      `WAITC(clk_src === tsfc_pkg::SRC_T1, 8500)
      `CHK("t1 span", 1'b1, cyc >= 8120)
      `CHK("t1 src", tsfc_pkg::SRC_T1, clk_src)
      // External clock mode skips the count
      cfg.mode <= tsfc_pkg::MODE_EC;
      reg_write(2'h0, 8'h38);
      `WAITC(startup_status === 1'b1, 30)
      `CHK("ec fast", 1'b1, startup_status)
      `WAITC(clk_src === tsfc_pkg::SRC_PRI, 20)
      `CHK("ec src", tsfc_pkg::SRC_PRI, clk_src)
      ext_run <= 1'b0;
      `WAITC(fail_active === 1'b1, 600)
      `CHK("ec fail", 1'b1, fail_active)
      // Reset in mid-run, while the failure stands
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK("rst fail", 1'b0, fail_active)
      `CHK("rst flag", 1'b0, osc_fail_flag)
      rst_n <= 1'b1;
      ext_run <= 1'b1;
      reg_write(2'h0, 8'h7A);
      reg_read(2'h0, rv);
      `CHK("scs set", 8'h7A, rv)
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      reg_read(2'h0, rv);
      `CHK("rst ctl", 8'h38, rv)
      stop_test();
   end
endmodule : tb_top
